// ---- rtl/vop_pkg.sv ----
/*
  Shared constants for the video output pad control block: register
  addresses, field positions, reset values and pad group indices.
  Assumes one clock domain (clk, 10 MHz) and byte-wide register access
  from the serial control port logic.
*/
package vop_pkg;

  // register addresses on the serial control port
  localparam logic [7:0] ADDR_XFER_CFG = 8'hf1;
  localparam logic [7:0] ADDR_GROUP_OE = 8'hf2;
  localparam logic [7:0] ADDR_STR_FAST = 8'hf8;
  localparam logic [7:0] ADDR_STR_SLOW = 8'hf9;

  // transfer configuration fields
  localparam int XFER_ASYNC_BIT = 0;
  localparam int XFER_FALL_BIT = 2;

  // group output enable fields
  localparam int GOE_REF_BIT = 0;
  localparam int GOE_PA_BIT = 1;
  localparam int GOE_PB_BIT = 2;
  localparam int GOE_PC_BIT = 3;
  localparam int GOE_KEY_BIT = 4;
  localparam logic [7:0] GOE_USED_MASK = 8'h1f;

  // strength register fields
  localparam int STR_LO_POS = 0;
  localparam int STR_MID_POS = 3;
  localparam int STR_TOP_POS = 6;
  localparam int STR_W = 3;

  // reset values
  localparam logic [7:0] XFER_CFG_RST = 8'h00;
  localparam logic [7:0] GROUP_OE_RST = 8'h1f;
  localparam logic [7:0] STR_FAST_RST = 8'h24;
  localparam logic [7:0] STR_SLOW_RST = 8'h24;

  // pad buffers per output pad
  localparam int PAD_BUFS = 8;

  // pad groups
  localparam int G_PCLK = 0;
  localparam int G_REF = 1;
  localparam int G_FLAG = 2;
  localparam int G_PA = 3;
  localparam int G_PB = 4;
  localparam int G_PC = 5;
  localparam int G_KEY = 6;
  localparam int NGRP = 7;

  // pixel clock divider in synchronous mode: one toggle per rising clk edge
  localparam int SYNC_DIV = 1;

  typedef enum logic [1:0] {
    VOP_TAP_NORMAL = 2'b00,
    VOP_TAP_BSCAN = 2'b01,
    VOP_TAP_HIGHZ = 2'b10
  } vop_tap_mode_t;

endpackage

// ---- rtl/vop_strength_decode.sv ----
/*
  Turns a 3-bit pad strength code into the enables of the eight
  parallel buffers of one pad.
  Assumes the code is stable register state; purely combinational.
*/
`timescale 1ns/1ps
module vop_strength_decode
  import vop_pkg::*;
(
  input wire logic [STR_W-1:0] code,
  output logic [PAD_BUFS-1:0] bufEn
);

  genvar b;
  generate
    for (b = 0; b < PAD_BUFS; b++) begin : g_buf
      // code n lights buffers 0..n, so n+1 of them
      assign bufEn[b] = (b <= int'(code));
    end
  endgenerate

endmodule

// ---- rtl/vop_pad_ctrl.sv ----
/*
  Video output pad control: pixel clock handling in synchronous and
  asynchronous transfer mode, output data registers, per-group pad
  strength and the tristate priority of the digital outputs.
  Assumes register writes arrive from the serial control port logic on
  clk, the boundary-scan controller state comes from logic on clk, and
  the pixel clock, chip clear and video enable pins are asynchronous.
*/
// Behaviour
// - in asynchronous mode the pixel clock pad is an input driven by the receiver
// - asynchronous data follows the rising or falling pixel clock edge per one bit
// - only one pixel clock edge per transfer, never both
// - double clock mode: each word takes one full pixel clock cycle
// - each pad is eight equal parallel buffers, code selects how many enabled
// - strength code n enables n plus one buffers
// - fast register: low bits port A, middle bits pixel clock and FIFO flags
// - pixel clock strength is middle field ORed with top bits shifted left one
// - slow register: low bits port B, middle bits reference and key pads
// - boundary scan overrides all; under EXTEST or CLAMP follow scan enables
// - boundary scan HIGHZ floats every output
// - chip clear low floats every output except scan data out
// - group bit clear floats outputs but pixel clock drives; set drives refs and flags
// - group register has separate enables for ports A, B, C and key; references and flags share one bit
// - video enable pin low drives data ports and key, high floats them
`timescale 1ns/1ps
module vop_pad_ctrl
  import vop_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  // register port from serial control logic
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regHit,
  // boundary-scan controller state
  input wire logic [1:0] tapMode,
  input wire logic [NGRP-1:0] bsDrive,
  // pins sampled from outside
  input wire logic chip_clear_n,
  input wire logic videoOe_n,
  // pixel clock pad
  input wire logic pixelTransferClockIn,
  output logic pixelTransferClockOut,
  output logic pixelTransferClockOe_n,
  // upstream pixel source
  input wire logic srcValid,
  input wire logic [7:0] srcPortA,
  input wire logic [7:0] srcPortB,
  input wire logic [7:0] srcPortC,
  input wire logic srcKey,
  input wire logic srcLineRef,
  input wire logic srcFieldRef,
  input wire logic srcPixelQual,
  input wire logic srcFifoEmpty,
  input wire logic srcFifoHalf,
  output logic srcTake,
  // output pads
  output logic [7:0] portA,
  output logic [7:0] portB,
  output logic [7:0] portC,
  output logic keyOut,
  output logic lineRef,
  output logic fieldRef,
  output logic pixelQualifier,
  output logic fifoEmptyFlag,
  output logic fifoHalfFullFlag,
  output logic [NGRP-1:0] groupOe_n,
  output logic [NGRP*PAD_BUFS-1:0] groupBufEn
);

  logic [7:0] xferCfg_ff;
  logic [7:0] groupOe_ff;
  logic [7:0] strFast_ff;
  logic [7:0] strSlow_ff;

  logic clearMeta_ff;
  logic clearSync_ff;
  logic oeMeta_ff;
  logic oeSync_ff;
  logic pclkMeta_ff;
  logic pclkSync_ff;
  logic pclkPrev_ff;
  logic syncPclk_ff;

  logic [7:0] portA_ff;
  logic [7:0] portB_ff;
  logic [7:0] portC_ff;
  logic key_ff;
  logic lineRef_ff;
  logic fieldRef_ff;
  logic pixQual_ff;
  logic fifoEmpty_ff;
  logic fifoHalf_ff;

  // register decode
  wire selXfer = (regAddr == ADDR_XFER_CFG);
  wire selGroup = (regAddr == ADDR_GROUP_OE);
  wire selFast = (regAddr == ADDR_STR_FAST);
  wire selSlow = (regAddr == ADDR_STR_SLOW);

  always_ff @(posedge clk) begin
    if (reset) begin
      xferCfg_ff <= XFER_CFG_RST;
      groupOe_ff <= GROUP_OE_RST;
      strFast_ff <= STR_FAST_RST;
      strSlow_ff <= STR_SLOW_RST;
    end else if (regWrite) begin
      if (selXfer) xferCfg_ff <= regWrData;
      if (selGroup) groupOe_ff <= regWrData & GOE_USED_MASK;
      if (selFast) strFast_ff <= regWrData;
      if (selSlow) strSlow_ff <= regWrData;
    end
  end

  assign regHit = selXfer | selGroup | selFast | selSlow;
  assign regRdData = selXfer ? xferCfg_ff :
                     selGroup ? groupOe_ff :
                     selFast ? strFast_ff :
                     selSlow ? strSlow_ff : 8'h00;

  wire asyncMode = xferCfg_ff[XFER_ASYNC_BIT];
  wire useFall = xferCfg_ff[XFER_FALL_BIT];

  // two-stage synchronisers for the asynchronous pins
  always_ff @(posedge clk) begin
    if (reset) begin
      clearMeta_ff <= 1'b0;
      clearSync_ff <= 1'b0;
      oeMeta_ff <= 1'b1;
      oeSync_ff <= 1'b1;
      pclkMeta_ff <= 1'b0;
      pclkSync_ff <= 1'b0;
      pclkPrev_ff <= 1'b0;
    end else begin
      clearMeta_ff <= chip_clear_n;
      clearSync_ff <= clearMeta_ff;
      oeMeta_ff <= videoOe_n;
      oeSync_ff <= oeMeta_ff;
      pclkMeta_ff <= pixelTransferClockIn;
      pclkSync_ff <= pclkMeta_ff;
      pclkPrev_ff <= pclkSync_ff;
    end
  end

  // edge finding on the received pixel clock
  wire pclkRise = pclkSync_ff & ~pclkPrev_ff;
  wire pclkFall = ~pclkSync_ff & pclkPrev_ff;
  // a single selected edge per transfer; the other edge is ignored
  wire asyncEdge = useFall ? pclkFall : pclkRise;

  // synchronous mode: the block makes the pixel clock itself at clk/2
  always_ff @(posedge clk) begin
    if (reset) begin
      syncPclk_ff <= 1'b0;
    end else if (asyncMode) begin
      syncPclk_ff <= 1'b0;
    end else begin
      syncPclk_ff <= ~syncPclk_ff;
    end
  end

  // new data is launched as the generated clock falls, ready for its rise
  wire syncEdge = ~asyncMode & syncPclk_ff;
  // one word per full pixel clock cycle, so a two-word pixel spans two cycles
  wire xferEdge = asyncMode ? asyncEdge : syncEdge;
  wire chipActive = clearSync_ff;
  wire takeNow = xferEdge & srcValid & chipActive;

  assign srcTake = takeNow;

  // output data registers hold their word until a transfer edge takes a valid word while chip clear is high
  always_ff @(posedge clk) begin
    if (reset) begin
      portA_ff <= 8'h00;
      portB_ff <= 8'h00;
      portC_ff <= 8'h00;
      key_ff <= 1'b0;
      pixQual_ff <= 1'b0;
    end else if (takeNow) begin
      portA_ff <= srcPortA;
      portB_ff <= srcPortB;
      portC_ff <= srcPortC;
      key_ff <= srcKey;
      pixQual_ff <= srcPixelQual;
    end
  end

  // sync references and flags move on the same edges; with no valid word they still track
  always_ff @(posedge clk) begin
    if (reset) begin
      lineRef_ff <= 1'b0;
      fieldRef_ff <= 1'b0;
      fifoEmpty_ff <= 1'b1;
      fifoHalf_ff <= 1'b0;
    end else if (xferEdge) begin
      lineRef_ff <= srcLineRef;
      fieldRef_ff <= srcFieldRef;
      fifoEmpty_ff <= srcFifoEmpty;
      fifoHalf_ff <= srcFifoHalf;
    end
  end

  assign portA = portA_ff;
  assign portB = portB_ff;
  assign portC = portC_ff;
  assign keyOut = key_ff;
  assign lineRef = lineRef_ff;
  assign fieldRef = fieldRef_ff;
  assign pixelQualifier = pixQual_ff;
  assign fifoEmptyFlag = fifoEmpty_ff;
  assign fifoHalfFullFlag = fifoHalf_ff;
  assign pixelTransferClockOut = syncPclk_ff;

  // tristate priority, resolved combinationally from current state
  wire tapScan = (tapMode == VOP_TAP_BSCAN);
  wire tapHighz = (tapMode == VOP_TAP_HIGHZ);
  wire videoPinOn = ~oeSync_ff;

  // per-group enable from the group register and the video enable pin
  logic [NGRP-1:0] groupReg;
  logic [NGRP-1:0] pinGated;

  // pixel clock has no group bit: it keeps running while groups float
  assign groupReg[G_PCLK] = 1'b1;
  // references and FIFO flags share one bit
  assign groupReg[G_REF] = groupOe_ff[GOE_REF_BIT];
  assign groupReg[G_FLAG] = groupOe_ff[GOE_REF_BIT];
  assign groupReg[G_PA] = groupOe_ff[GOE_PA_BIT];
  assign groupReg[G_PB] = groupOe_ff[GOE_PB_BIT];
  assign groupReg[G_PC] = groupOe_ff[GOE_PC_BIT];
  assign groupReg[G_KEY] = groupOe_ff[GOE_KEY_BIT];

  // the video enable pin reaches only data ports and key
  assign pinGated[G_PCLK] = 1'b0;
  assign pinGated[G_REF] = 1'b0;
  assign pinGated[G_FLAG] = 1'b0;
  assign pinGated[G_PA] = 1'b1;
  assign pinGated[G_PB] = 1'b1;
  assign pinGated[G_PC] = 1'b1;
  assign pinGated[G_KEY] = 1'b1;

  // in asynchronous mode the pixel clock pad only listens
  logic [NGRP-1:0] roleDrives;
  assign roleDrives = {{(NGRP-1){1'b1}}, ~asyncMode};

  genvar g;
  generate
    for (g = 0; g < NGRP; g++) begin : g_oe
      wire normalDrive = roleDrives[g] & groupReg[g] & (~pinGated[g] | videoPinOn);
      // scan first, then HIGHZ, then chip clear, then group bits and pin
      wire drive = tapScan ? bsDrive[g] :
                   tapHighz ? 1'b0 :
                   ~chipActive ? 1'b0 :
                   normalDrive;
      assign groupOe_n[g] = ~drive;
    end
  endgenerate

  assign pixelTransferClockOe_n = groupOe_n[G_PCLK];

  // strength codes per group
  logic [STR_W-1:0] grpCode [NGRP];
  wire [STR_W-1:0] fastMid = strFast_ff[STR_MID_POS +: STR_W];
  wire [1:0] fastTop = strFast_ff[STR_TOP_POS +: 2];
  wire [STR_W-1:0] slowMid = strSlow_ff[STR_MID_POS +: STR_W];

  // pixel clock gets extra strength from the top bits
  assign grpCode[G_PCLK] = fastMid | {fastTop, 1'b0};
  assign grpCode[G_FLAG] = fastMid;
  assign grpCode[G_PA] = strFast_ff[STR_LO_POS +: STR_W];
  // port C has no field of its own and shares the port B code
  assign grpCode[G_PB] = strSlow_ff[STR_LO_POS +: STR_W];
  assign grpCode[G_PC] = strSlow_ff[STR_LO_POS +: STR_W];
  assign grpCode[G_REF] = slowMid;
  assign grpCode[G_KEY] = slowMid;

  generate
    for (g = 0; g < NGRP; g++) begin : g_str
      // one decoder per pad group
      vop_strength_decode u_dec (
        .code(grpCode[g]),
        .bufEn(groupBufEn[g*PAD_BUFS +: PAD_BUFS])
      );
    end
  endgenerate

endmodule

// ---- testbench/vop_pad_ctrl_props.sv ----
/* assertions on the pad control block ports.
   assumes pin inputs reach groupOe_n within three clk samples. */
`timescale 1ns/1ps
module vop_pad_ctrl_props
  import vop_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regRdData,
  input wire logic [1:0] tapMode,
  input wire logic [NGRP-1:0] bsDrive,
  input wire logic chip_clear_n,
  input wire logic videoOe_n,
  input wire logic pixelTransferClockOe_n,
  input wire logic srcTake,
  input wire logic [7:0] srcPortA,
  input wire logic [7:0] portA,
  input wire logic [NGRP-1:0] groupOe_n,
  input wire logic [NGRP*PAD_BUFS-1:0] groupBufEn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [1:0] upCnt_ff;
  logic [1:0] nxt_upCnt;
  wire logic [7:0] rd = regRdData;
  // three high samples guarantee the synchroniser has let go of chip clear
  wire logic up = upCnt_ff == 2'd3 && tapMode == 2'b00;
  assign nxt_upCnt = !chip_clear_n ? 2'd0 : upCnt_ff + {1'b0, upCnt_ff != 2'd3};
  always_ff @(posedge clk) upCnt_ff <= reset ? 2'd0 : nxt_upCnt;
  function automatic logic [7:0] th(input logic [2:0] n);
    return 8'hff >> (3'd7 - n);
  endfunction
  sequence vidOn; !videoOe_n [*3]; endsequence
  sequence vidOff; videoOe_n [*3]; endsequence
  a_scan_follows: assert property (tapMode == 2'b01 |-> groupOe_n == ~bsDrive)
    else $error("scan enables ignored");
  a_highz_floats: assert property (tapMode == 2'b10 |-> &groupOe_n)
    else $error("highz not floating");
  a_clear_floats: assert property (!chip_clear_n [*3] ##0 tapMode != 2'b01 |-> &groupOe_n)
    else $error("chip clear not floating");
  a_group_refs: assert property (up && regAddr == ADDR_GROUP_OE |-> groupOe_n[2:1] == {2{~rd[0]}})
    else $error("reference group enable wrong");
  a_video_float: assert property (vidOff ##0 tapMode != 2'b01 |-> &groupOe_n[6:3])
    else $error("video pin high but ports drive");
  a_video_drive: assert property (vidOn ##0 up && regAddr == ADDR_GROUP_OE |->
    groupOe_n[6:3] == ~rd[4:1])
    else $error("video group enable wrong");
  a_pclk_pad: assert property (pixelTransferClockOe_n == groupOe_n[G_PCLK])
    else $error("pixel clock pad enable differs");
  a_fast_str: assert property (regAddr == ADDR_STR_FAST |->
    groupBufEn[31:16] == {th(rd[2:0]), th(rd[5:3])} && groupBufEn[7:0] == th(rd[5:3] | {rd[7:6], 1'b0}))
    else $error("fast strength wrong");
  a_slow_str: assert property (regAddr == ADDR_STR_SLOW |->
    groupBufEn[55:32] == {th(rd[5:3]), th(rd[2:0]), th(rd[2:0])} && groupBufEn[15:8] == th(rd[5:3]))
    else $error("slow strength wrong");
  a_one_edge: assert property (srcTake |=> !srcTake)
    else $error("two takes in a row");
  a_take_load: assert property (srcTake |=> portA == $past(srcPortA))
    else $error("taken word not loaded");
  a_data_hold: assert property (!srcTake |=> $stable(portA))
    else $error("port changed without take");
endmodule
bind vop_pad_ctrl vop_pad_ctrl_props u_props (.clk, .reset, .regAddr, .regRdData, .tapMode, .bsDrive,
  .chip_clear_n, .videoOe_n, .pixelTransferClockOe_n, .srcTake, .srcPortA, .portA, .groupOe_n, .groupBufEn);

// ---- testbench/vop_capture_model.sv ----
/* far-side capture logic: paces asynchronous transfers with its own pixel
   clock and latches port A. assumes the edge mode is set while idle. */
`timescale 1ns/1ps
module vop_capture_model #(
  parameter int HALF = 400
) (
  input wire logic run,
  input wire logic fallEdge,
  input wire logic [7:0] portA,
  output logic pixelClk,
  output logic [7:0] capWord
);
  initial begin
    pixelClk = 1'b0;
    capWord = 8'h00;
  end
  // idle level sits before the active edge, so the clock stands still between frames
  always @(fallEdge) begin
    if (!run) begin
      pixelClk = fallEdge;
    end
  end
  always begin
    wait (run);
    #HALF;
    if (run) begin
      pixelClk = ~pixelClk;
    end
  end
  // a word launched after one active edge is latched a full cycle later
  always @(pixelClk) begin
    if (run && pixelClk != fallEdge) begin
      capWord = portA;
    end
  end
endmodule

// ---- testbench/tb_top.sv ----
/* self-checking bench: registers, tristate priority, strength, asynchronous
   transfers through the capture model. assumes the block of rtl/. */
`timescale 1ns/1ps
module tb_top
  import vop_pkg::*;
;
  logic clk = 1'b0, reset = 1'b1, regWrite = 1'b0, chip_clear_n = 1'b1, videoOe_n = 1'b1;
  logic srcValid = 1'b1, run = 1'b0, fe = 1'b0, regHit, srcTake, pclkOut, pclkOe_n, pclk;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, sA = 8'h00, sB = 8'h00, sC = 8'h00;
  logic [7:0] regRdData, pA, pB, pC, capWord, cur, held, ex, f1, f2, f8, f9;
  logic [5:0] sM = 6'h00;
  logic [1:0] tapMode = 2'b00;
  logic [6:0] bsDrive = 7'h00, gOe_n;
  logic [55:0] gBuf;
  logic [7:0] q[$];
  int error_cnt = 0, total_checks = 0;
  always #50 clk = ~clk;
  vop_pad_ctrl uut (.clk, .reset, .regWrite, .regAddr, .regWrData, .regRdData, .regHit, .tapMode, .bsDrive,
    .chip_clear_n, .videoOe_n, .pixelTransferClockIn(pclk), .pixelTransferClockOut(pclkOut),
    .pixelTransferClockOe_n(pclkOe_n), .srcValid, .srcPortA(sA), .srcPortB(sB), .srcPortC(sC), .srcKey(sM[0]),
    .srcLineRef(sM[1]), .srcFieldRef(sM[2]), .srcPixelQual(sM[3]), .srcFifoEmpty(sM[4]), .srcFifoHalf(sM[5]),
    .srcTake, .portA(pA), .portB(pB), .portC(pC), .keyOut(), .lineRef(), .fieldRef(), .pixelQualifier(),
    .fifoEmptyFlag(), .fifoHalfFullFlag(), .groupOe_n(gOe_n), .groupBufEn(gBuf));
  vop_capture_model cap (.run, .fallEdge(fe), .portA(pA), .pixelClk(pclk), .capWord);
  function automatic logic [7:0] th(input logic [2:0] n);
    return 8'hff >> (3'd7 - n);
  endfunction
  function automatic logic [55:0] expBuf();
    return {th(f9[5:3]), th(f9[2:0]), th(f9[2:0]), th(f8[2:0]), th(f8[5:3]), th(f9[5:3]),
      th(f8[5:3] | {f8[7:6], 1'b0})};
  endfunction
  function automatic logic [6:0] expOe(input logic [1:0] t, input logic [6:0] b, input logic c, v);
    if (t == 2'b01) return ~b;
    if (t == 2'b10 || !c) return 7'h7f;
    return {{4{v}} | ~f2[4:1], {2{~f2[0]}}, f1[0]};
  endfunction
  task automatic report(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      error_cnt++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic chk_byte(input logic [7:0] g, e);
    report(g === e, "byte value");
  endtask
  task automatic chk_oe(input logic [6:0] g, e);
    report(g === e, "group enables");
  endtask
  task automatic chk_buf(input logic [55:0] g, e);
    report(g === e, "buffer enables");
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    #2 regWrite = 1'b1;
    regAddr = a;
    regWrData = d;
    @(posedge clk);
    #2 regWrite = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e, input logic hit);
    @(posedge clk);
    #2 regAddr = a;
    #1 chk_byte(regRdData, e);
    chk_byte({7'h00, regHit}, {7'h00, hit});
  endtask
  task automatic do_reset();
    @(posedge clk);
    #2 reset = 1'b1;
    repeat (6) @(posedge clk);
    #2 reset = 1'b0;
    f1 = 8'h00;
    f2 = 8'h1f;
    f8 = 8'h24;
    f9 = 8'h24;
    rd(ADDR_XFER_CFG, f1, 1'b1);
    rd(ADDR_GROUP_OE, f2, 1'b1);
    rd(ADDR_STR_FAST, f8, 1'b1);
    rd(ADDR_STR_SLOW, f9, 1'b1);
    chk_buf(gBuf, expBuf());
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #500000;
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end
  initial begin
    void'($urandom(50));
    do_reset();
    for (int i = 0; i < 40; i++) begin
      chip_clear_n = 1'b1;
      f1 = {5'h00, 1'($urandom), 1'b0, 1'($urandom)};
      wr(ADDR_XFER_CFG, f1);
      f2 = 8'($urandom);
      wr(ADDR_GROUP_OE, f2);
      f2 &= 8'h1f;
      @(posedge clk);
      #2 tapMode = 2'($urandom);
      bsDrive = 7'($urandom);
      chip_clear_n = |2'($urandom);
      videoOe_n = 1'($urandom);
      {sA, sB, sC, sM} = 30'($urandom);
      regAddr = ADDR_GROUP_OE;
      // pins pass a two-stage synchroniser first
      repeat (3) @(posedge clk);
      #2 chk_oe(gOe_n, expOe(tapMode, bsDrive, chip_clear_n, videoOe_n));
    end
    tapMode = 2'b00;
    chip_clear_n = 1'b1;
    rd(ADDR_GROUP_OE, f2, 1'b1);
    rd(8'h37, 8'h00, 1'b0);
    for (int i = 0; i < 12; i++) begin
      f8 = i < 2 ? {8{i[0]}} : 8'($urandom);
      f9 = i < 2 ? ~f8 : 8'($urandom);
      wr(ADDR_STR_FAST, f8);
      wr(ADDR_STR_SLOW, f9);
      rd(ADDR_STR_FAST, f8, 1'b1);
      rd(ADDR_STR_SLOW, f9, 1'b1);
      chk_buf(gBuf, expBuf());
    end
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_XFER_CFG, {5'h00, m[0], 2'b01});
      fe = m[0];
      cur = 8'($urandom);
      sA = cur;
      sB = ~cur;
      sC = cur ^ 8'h5a;
      #35 run = 1'b1;
      for (int k = 0; k < 8; k++) begin
        wait (pclk != fe);
        #1 held = srcValid ? cur : held;
        q.push_back(held);
        chk_byte({6'h00, pclkOut, pclkOe_n}, 8'h01);
        if (k > 0) begin
          ex = q.pop_front();
          chk_byte(capWord, ex);
          chk_byte(pB, ~ex);
          chk_byte(pC, ex ^ 8'h5a);
        end
        wait (pclk == fe);
        @(posedge clk);
        #2 cur = 8'($urandom);
        sA = cur;
        sB = ~cur;
        sC = cur ^ 8'h5a;
        srcValid = k != 3;
      end
      run = 1'b0;
      // let the model's pending half period run out so the next mode starts from a clean idle level
      repeat (6) @(posedge clk);
      q.delete();
    end
    wr(ADDR_XFER_CFG, 8'h00);
    do_reset();
    results();
  end
endmodule
